// ==== rtl/spi_port_consts.svh ====
// register map, field positions, reset values and counts of the spi port
// assumes byte-wide registers on an 8-bit address space
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH
`define SPI_CTRL_ADDR 8'hc3
`define SPI_STAT_ADDR 8'hc4
`define SPI_DATA_ADDR 8'hc5
`define SPI_MASK_ADDR 8'hc6
`define SPI_CTRL_RST 8'h14
`define SPI_STAT_RST 8'h00
`define SPI_DATA_RST 8'h00
`define SPI_MASK_RST 8'h00
// spi_control fields
`define C_RATE2 7
`define C_EN 6
`define C_SSDIS 5
`define C_MASTER_SELECT_BIT 4
`define C_CLOCK_IDLE_POLARITY 3
`define C_CLOCK_SAMPLE_PHASE 2
`define C_RATE1 1
`define C_RATE0 0
// spi_status_flags fields, the mask register shares the layout
`define S_DONE 7
`define S_WRITE_COLLISION_FLAG 6
`define S_SELECT_ERROR_FLAG 5
`define S_MODE_FAULT_FLAG 4
`define S_TXE 3
`define S_ORDER 2
`define S_REMAP 1
`define S_TX_EMPTY_IRQ_ENABLE 0
// mask bit 0 is the global port interrupt enable
`define M_IRQEN 0
`define XFER_BITS 4'd8
`define RATE_TIMER 3'h7
`endif

// ==== rtl/spi_port_pkg.sv ====
// types shared by the spi port files
// assumes nothing beyond a SystemVerilog elaborator
package spi_port_pkg;
   typedef enum logic [1:0] {st_idle, st_arm, st_run} xfer_state_t;
endpackage

// ==== rtl/pin_sync.sv ====
// two flip-flop synchroniser for one pin input
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/1ps
module pin_sync
#(
   parameter logic RST_VAL = 1'b0
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic meta_q;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ==== rtl/sck_rate_div.sv ====
// half-period tick for the master serial clock
// assumes t1_ovf is a one-cycle pulse on sys_clk
`timescale 1ns/1ps
`include "spi_port_consts.svh"
module sck_rate_div
#(
   parameter int CNT_W = 6
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [2:0] code,
   input wire logic t1_ovf,
   output logic tick
);
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;
   initial
   begin
      if (CNT_W < 6)
         $error("sck_rate_div: CNT_W must be at least 6");
   end
   // below code 7 the half period is 2**code clocks, so sck is the clock over 2**(code+1); code 7 ticks on t1_ovf
   always_comb
   begin
      limit = CNT_W'((8'd1 << code) - 8'd1);
      if (code == `RATE_TIMER)
         tick = run & t1_ovf;
      else
         tick = run & (cnt_q == limit);
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_q <= '0;
      else if (!run || tick)
         cnt_q <= '0;
      else
         cnt_q <= cnt_q + 1'b1;
   end
endmodule

// ==== rtl/spi_port.sv ====
// byte-wide spi port, master or slave, with status, data and control regs
// assumes a single-cycle register port on sys_clk and raw pins outside
`timescale 1ns/1ps
`include "spi_port_consts.svh"
module spi_port
#(
   parameter int ADDR_W = 8
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rd_data,
   input wire logic t1_ovf,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic ss_n_in,
   output logic irq
);
   import spi_port_pkg::*;

   logic sck_s;
   logic mosi_s;
   logic miso_s;
   logic ss_n_s;
   logic tick;
   logic ctrl_sel;
   logic stat_sel;
   logic data_sel;
   logic mask_sel;
   logic [7:0] ctrl_q;
   logic [7:0] mask_q;
   logic order_q;
   logic remap_q;
   logic tx_empty_irq_enable_q;
   logic done_q;
   logic write_collision_flag_q;
   logic select_error_flag_q;
   logic mode_fault_flag_q;
   logic txe_q;
   logic stat_seen_q;
   logic mode_fault_flag_seen_q;
   logic [7:0] rx_q;
   logic [7:0] tx_buf_q;
   logic tx_full_q;
   xfer_state_t state_q;
   logic [7:0] txs_q;
   logic [7:0] rxs_q;
   logic [3:0] cnt_q;
   logic phase_q;
   logic sck_d1_q;
   logic ss_d1_q;
   logic en;
   logic master_select_bit;
   logic clock_idle_polarity;
   logic clock_sample_phase;
   logic ssdis;
   logic slave_sel;
   logic shifting;
   logic lead;
   logic trail;
   logic sample;
   logic drive;
   logic finish;
   logic in_bit;
   logic out_bit;
   logic [7:0] rx_next;
   logic [3:0] cnt_next;
   logic master_go;
   logic slave_go;
   logic mode_fault_flag_evt;
   logic select_error_flag_evt;
   logic data_wr;
   logic data_acc;
   logic write_collision_flag_evt;
   logic ctrl_wr;
   logic stat_wr;
   logic disable_wr;

   initial
   begin
      if (ADDR_W < 8)
         $error("spi_port: ADDR_W must be at least 8");
   end

   pin_sync #(.RST_VAL(1'b0)) u_sync_sck
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d(sck_in),
      .q(sck_s)
   );
   pin_sync #(.RST_VAL(1'b0)) u_sync_mosi
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d(mosi_in),
      .q(mosi_s)
   );
   pin_sync #(.RST_VAL(1'b0)) u_sync_miso
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d(miso_in),
      .q(miso_s)
   );
   // select idles high so reset does not look like a selected slave
   pin_sync #(.RST_VAL(1'b1)) u_sync_ss
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d(ss_n_in),
      .q(ss_n_s)
   );

   sck_rate_div #(.CNT_W(6)) u_rate
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .run(state_q == st_run && master_select_bit),
      .code({ctrl_q[`C_RATE2], ctrl_q[`C_RATE1], ctrl_q[`C_RATE0]}),
      .t1_ovf(t1_ovf),
      .tick(tick)
   );

   always_comb
   begin
      ctrl_sel = 1'b0;
      stat_sel = 1'b0;
      data_sel = 1'b0;
      mask_sel = 1'b0;
      if (addr == ADDR_W'(`SPI_CTRL_ADDR))
         ctrl_sel = 1'b1;
      else if (addr == ADDR_W'(`SPI_STAT_ADDR))
         stat_sel = 1'b1;
      else if (addr == ADDR_W'(`SPI_DATA_ADDR))
         data_sel = 1'b1;
      else if (addr == ADDR_W'(`SPI_MASK_ADDR))
         mask_sel = 1'b1;
   end

   always_comb
   begin
      en = ctrl_q[`C_EN];
      master_select_bit = ctrl_q[`C_MASTER_SELECT_BIT];
      clock_idle_polarity = ctrl_q[`C_CLOCK_IDLE_POLARITY];
      clock_sample_phase = ctrl_q[`C_CLOCK_SAMPLE_PHASE];
      ssdis = ctrl_q[`C_SSDIS];
      slave_sel = ssdis | ~ss_n_s;
      shifting = (state_q == st_run) || (state_q == st_arm);
      // master edges come from its own divider, slave edges from the pin
      if (master_select_bit)
      begin
         lead = tick & ~phase_q;
         trail = tick & phase_q;
      end
      else
      begin
         lead = shifting && (sck_s != sck_d1_q) && (sck_d1_q == clock_idle_polarity);
         trail = shifting && (sck_s != sck_d1_q) && (sck_d1_q != clock_idle_polarity);
      end
      sample = clock_sample_phase ? trail : lead;
      // with late phase the first bit is already on the line
      drive = clock_sample_phase ? (lead && cnt_q != 4'd0) : trail;
      in_bit = master_select_bit ? miso_s : mosi_s;
      out_bit = order_q ? txs_q[0] : txs_q[7];
      rx_next = order_q ? {in_bit, rxs_q[7:1]} : {rxs_q[6:0], in_bit};
      cnt_next = cnt_q + {3'd0, sample};
      finish = (master_select_bit ? trail : sample) && (cnt_next == `XFER_BITS);
      master_go = state_q == st_idle && en && master_select_bit && tx_full_q;
      // only a leading edge starts a byte; the last byte's trailing edge
      // arrives while already re-armed and must not start another
      slave_go = state_q == st_arm && lead;
      mode_fault_flag_evt = en && master_select_bit && !ssdis && !ss_n_s;
      select_error_flag_evt = state_q == st_run && !master_select_bit && !ssdis && ss_n_s
         && !ss_d1_q;
      data_wr = wr_stb && data_sel;
      data_acc = data_sel && (wr_stb || rd_stb);
      write_collision_flag_evt = data_wr && state_q == st_run;
      ctrl_wr = wr_stb && ctrl_sel;
      stat_wr = wr_stb && stat_sel;
      disable_wr = ctrl_wr && !wr_data[`C_EN];
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_q <= `SPI_CTRL_RST;
      else if (mode_fault_flag_evt)
      begin
         ctrl_q <= ctrl_q;
         ctrl_q[`C_EN] <= 1'b0;
         ctrl_q[`C_MASTER_SELECT_BIT] <= 1'b0;
      end
      else if (ctrl_wr)
         ctrl_q <= wr_data;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mask_q <= `SPI_MASK_RST;
         order_q <= 1'b0;
         remap_q <= 1'b0;
         tx_empty_irq_enable_q <= 1'b0;
      end
      else
      begin
         if (wr_stb && mask_sel)
            mask_q <= wr_data;
         if (stat_wr)
         begin
            order_q <= wr_data[`S_ORDER];
            remap_q <= wr_data[`S_REMAP];
            tx_empty_irq_enable_q <= wr_data[`S_TX_EMPTY_IRQ_ENABLE];
         end
      end
   end

   // clear sequences: a status read arms, the following access clears
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stat_seen_q <= 1'b0;
         mode_fault_flag_seen_q <= 1'b0;
      end
      else
      begin
         if (stat_sel && (rd_stb || wr_stb))
            stat_seen_q <= 1'b1;
         else if (data_acc)
            stat_seen_q <= 1'b0;
         if (stat_sel && rd_stb && mode_fault_flag_q)
            mode_fault_flag_seen_q <= 1'b1;
         else if (ctrl_wr)
            mode_fault_flag_seen_q <= 1'b0;
      end
   end

   // every flag lets a hardware set win over a clear in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         select_error_flag_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
         txe_q <= 1'b0;
      end
      else
      begin
         if (finish)
            done_q <= 1'b1;
         else if ((stat_seen_q && data_acc)
            || (stat_wr && wr_data[`S_DONE]))
            done_q <= 1'b0;
         if (write_collision_flag_evt)
            write_collision_flag_q <= 1'b1;
         else if ((stat_seen_q && data_acc)
            || (stat_wr && wr_data[`S_WRITE_COLLISION_FLAG]))
            write_collision_flag_q <= 1'b0;
         if (select_error_flag_evt)
            select_error_flag_q <= 1'b1;
         else if (disable_wr)
            select_error_flag_q <= 1'b0;
         if (mode_fault_flag_evt)
            mode_fault_flag_q <= 1'b1;
         else if ((mode_fault_flag_seen_q && ctrl_wr)
            || (stat_wr && wr_data[`S_MODE_FAULT_FLAG]))
            mode_fault_flag_q <= 1'b0;
         if (master_go || (slave_go && tx_full_q))
            txe_q <= 1'b1;
         else if ((data_wr && !write_collision_flag_evt)
            || (stat_wr && wr_data[`S_TXE]))
            txe_q <= 1'b0;
      end
   end

   // transmit buffer: a collided write is dropped
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_buf_q <= `SPI_DATA_RST;
         tx_full_q <= 1'b0;
      end
      else if (data_wr && !write_collision_flag_evt)
      begin
         tx_buf_q <= wr_data;
         tx_full_q <= 1'b1;
      end
      else if (!en || master_go || (slave_go && tx_full_q))
         tx_full_q <= 1'b0;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= st_idle;
         cnt_q <= 4'd0;
         phase_q <= 1'b0;
      end
      else if (!en || mode_fault_flag_evt || select_error_flag_evt || finish)
      begin
         state_q <= st_idle;
         cnt_q <= 4'd0;
         phase_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            st_idle:
            begin
               if (master_go)
                  state_q <= st_run;
               else if (!master_select_bit && slave_sel)
                  state_q <= st_arm;
            end
            st_arm:
            begin
               if (!slave_sel)
                  state_q <= st_idle;
               else if (slave_go)
                  state_q <= st_run;
            end
            default:
            begin
               state_q <= st_run;
            end
         endcase
         if (state_q != st_idle)
         begin
            cnt_q <= cnt_next;
            if (tick)
               phase_q <= ~phase_q;
         end
      end
   end

   // shifters; an armed slave keeps reloading until the first edge
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txs_q <= 8'h00;
         rxs_q <= 8'h00;
         rx_q <= `SPI_DATA_RST;
      end
      else
      begin
         if (master_go)
            txs_q <= tx_buf_q;
         else if (state_q == st_arm && !lead)
            txs_q <= tx_full_q ? tx_buf_q : rx_q;
         else if (drive)
            txs_q <= order_q ? {1'b0, txs_q[7:1]} : {txs_q[6:0], 1'b0};
         if (sample)
            rxs_q <= rx_next;
         if (finish)
            rx_q <= sample ? rx_next : rxs_q;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_d1_q <= 1'b0;
         ss_d1_q <= 1'b1;
      end
      else
      begin
         sck_d1_q <= sck_s;
         ss_d1_q <= ss_n_s;
      end
   end

   // pins are registered so every output leaves a flip-flop
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
         mosi_out <= 1'b0;
         mosi_oe <= 1'b0;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
      end
      else
      begin
         sck_out <= clock_idle_polarity ^ phase_q;
         sck_oe <= en && master_select_bit;
         mosi_out <= out_bit;
         mosi_oe <= en && master_select_bit;
         miso_out <= out_bit;
         miso_oe <= en && !master_select_bit && slave_sel;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= 8'h00;
      else if (!rd_stb)
         rd_data <= 8'h00;
      else if (ctrl_sel)
         rd_data <= ctrl_q;
      else if (stat_sel)
         rd_data <= {done_q, write_collision_flag_q, select_error_flag_q, mode_fault_flag_q, txe_q, order_q,
            remap_q, tx_empty_irq_enable_q};
      else if (data_sel)
         rd_data <= rx_q;
      else if (mask_sel)
         rd_data <= mask_q;
      else
         rd_data <= 8'h00;
   end

   // collision and select error never reach the interrupt
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq <= 1'b0;
      else
         irq <= mask_q[`M_IRQEN] && ((done_q && mask_q[`S_DONE])
            || (mode_fault_flag_q && mask_q[`S_MODE_FAULT_FLAG])
            || (txe_q && tx_empty_irq_enable_q && mask_q[`S_TXE]));
   end
endmodule

// ==== sim/spi_port_properties.sv ====
// checker bound to the ports of spi_port
// assumes the register map in spi_port_consts.svh
`timescale 1ns/1ps
`include "spi_port_consts.svh"
module spi_port_properties
#(
   parameter int ADDR_W = 8
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic ss_n_in,
   input wire logic irq
);
   logic [7:0] ctl_q, mask_q, mp_q, cnt_q;
   logic ie_q, iep_q, srd_q, sck_q, seen_q, tog, cp_q;
   logic [2:0] code;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   assign tog = sck_out != sck_q;
   assign code = {ctl_q[`C_RATE2], ctl_q[`C_RATE1], ctl_q[`C_RATE0]};
   // shadows of software writes; hardware clears are not mirrored
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_q <= `SPI_CTRL_RST;
         mask_q <= 8'h00;
         mp_q <= 8'h00;
         ie_q <= 1'b0;
         iep_q <= 1'b0;
         srd_q <= 1'b0;
         cp_q <= 1'b0;
      end
      else
      begin
         // the pin follows a control write one cycle late
         cp_q <= ctl_q[`C_CLOCK_IDLE_POLARITY];
         mp_q <= mask_q;
         iep_q <= ie_q;
         srd_q <= rd_stb && addr == `SPI_STAT_ADDR;
         if (wr_stb && addr == `SPI_CTRL_ADDR)
            ctl_q <= wr_data;
         if (wr_stb && addr == `SPI_MASK_ADDR)
            mask_q <= wr_data;
         if (wr_stb && addr == `SPI_STAT_ADDR)
            ie_q <= wr_data[`S_TX_EMPTY_IRQ_ENABLE];
      end
   end
   // any write restarts the measure, so idle gaps are never judged
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_q <= 1'b0;
         seen_q <= 1'b0;
         cnt_q <= 8'h00;
      end
      else
      begin
         sck_q <= sck_out;
         seen_q <= !wr_stb && (seen_q || tog);
         cnt_q <= tog ? 8'h01 : cnt_q + {7'h00, cnt_q != 8'hff};
      end
   end
   a_rd_idle_zero: assert property (!rd_stb |=> rd_data == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (rd_stb &&
      (addr < `SPI_CTRL_ADDR || addr > `SPI_MASK_ADDR) |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_half_period: assert property (tog && seen_q && sck_oe &&
      code != `RATE_TIMER |-> cnt_q == 8'h01 << code)
      else $error("serial clock half period wrong");
   a_irq_gate: assert property (irq |-> mp_q[0] &&
      (mp_q[7] || mp_q[4] || mp_q[3] && iep_q))
      else $error("interrupt without an enabled source");
   a_flag_irq: assert property (srd_q && mp_q[0] &&
      (rd_data[7] && mp_q[7] || rd_data[3] && mp_q[3] && iep_q) |-> irq)
      else $error("enabled flag set but no interrupt");
   a_mode_fault_flag_stops_sck: assert property (ctl_q[`C_EN] &&
      ctl_q[`C_MASTER_SELECT_BIT] && !ctl_q[`C_SSDIS] && !ss_n_in |-> ##[1:8] !sck_oe)
      else $error("master kept driving after mode fault");
   a_oe_exclusive: assert property (!(mosi_oe && miso_oe))
      else $error("master and slave outputs both on");
   // no divided half period exceeds 64 clocks, so a longer quiet spell is idle
   a_idle_level: assert property (sck_oe && cnt_q > 8'h40 &&
      code != `RATE_TIMER |-> sck_out == cp_q)
      else $error("serial clock not at its idle level");
endmodule
bind spi_port spi_port_properties #(.ADDR_W(ADDR_W)) u_props
(
   .sys_clk, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
   .sck_out, .sck_oe, .mosi_oe, .miso_oe, .ss_n_in, .irq
);

// ==== sim/spi_peer.sv ====
// slave model on the serial pins, idle-low clock, early phase only
// assumes sck and mosi come registered on sys_clk
`timescale 1ns/1ps
module spi_peer
(
   input wire logic sys_clk,
   input wire logic sck,
   input wire logic mosi,
   input wire logic load,
   input wire logic [7:0] load_byte,
   output logic miso = 1'b0,
   output logic [7:0] rx_byte = 8'h00
);
   logic sck_q = 1'b0;
   logic [7:0] sh_q = 8'h00;
   logic [3:0] n_q = 4'h0;
   always @(posedge sys_clk)
   begin
      sck_q <= sck;
      if (load)
      begin
         sh_q <= load_byte;
         n_q <= 4'h0;
         miso <= load_byte[7];
      end
      else if (sck && !sck_q)
         rx_byte <= {rx_byte[6:0], mosi};
      else if (!sck && sck_q)
      begin
         sh_q <= {sh_q[6:0], 1'b0};
         n_q <= n_q + 4'h1;
         // released after the byte: show the inverse, never a stale bit
         miso <= (n_q == 4'h7) ? ~miso : sh_q[6];
      end
   end
endmodule

// ==== sim/spi_port_tb.sv ====
// self-checking bench for spi_port as master against a slave model, then as slave driven by the bench
// assumes the register map in spi_port_consts.svh
`timescale 1ns/1ps
`include "spi_port_consts.svh"
module spi_port_tb;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic t1_ovf = 1'b0;
   logic ss_n_in = 1'b1;
   logic sck_pin = 1'b0;
   logic mosi_pin = 1'b0;
   logic ld = 1'b0;
   logic [7:0] ld_byte = 8'h00;
   logic [7:0] rd_data, peer_rx;
   logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic miso_in, irq;
   logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 86603;
   always #20 sys_clk = ~sys_clk;
   spi_port DUT
   (
      .sys_clk, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
      .t1_ovf, .sck_in(sck_pin), .sck_out, .sck_oe, .mosi_in(mosi_pin),
      .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe, .ss_n_in, .irq
   );
   spi_peer peer
   (
      .sys_clk, .sck(sck_out), .mosi(mosi_out), .load(ld),
      .load_byte(ld_byte), .miso(miso_in), .rx_byte(peer_rx)
   );
   task automatic final_report();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // five bytes at most 16 x 9 clocks each: far below the ceiling
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      t1_ovf <= (cyc % 9 == 8);
      if (cyc == 20000)
      begin
         num_errors++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, exp, m);
      @(posedge sys_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1;
      chk(rd_data & m, exp & m);
   endtask
   task automatic half(output int h);
      logic s;
      @(negedge sys_clk);
      s = sck_out;
      h = 0;
      for (int k = 0; k < 400 && sck_out === s; k++)
         @(negedge sys_clk);
      s = sck_out;
      while (sck_out === s && h < 400)
      begin
         @(negedge sys_clk);
         h++;
      end
   endtask
   // bench as external master, idle-low clock, early phase, 8-clock halves
   task automatic slv(input logic [7:0] m, input int n,
      output logic [7:0] got);
      got = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         mosi_pin <= m[7-i];
         repeat (8) @(posedge sys_clk);
         got = {got[6:0], miso_out};
         sck_pin <= 1'b1;
         repeat (8) @(posedge sys_clk);
         sck_pin <= 1'b0;
      end
      repeat (8) @(posedge sys_clk);
   endtask
   function automatic logic [7:0] half_exp(input logic [2:0] c);
      return (c == `RATE_TIMER) ? 8'h09 : 8'h01 << c;
   endfunction
   initial
   begin
      logic [7:0] tx, rxb, sb, m1, m2, got;
      logic [2:0] code;
      int h;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(`SPI_CTRL_ADDR, `SPI_CTRL_RST, 8'hff);
      rd(`SPI_STAT_ADDR, 8'h00, 8'hff);
      rd(`SPI_DATA_ADDR, 8'h00, 8'hff);
      rd(8'hc7, 8'h00, 8'hff);
      wr(`SPI_MASK_ADDR, 8'h81);
      foreach (codes[i])
      begin
         code = codes[i];
         tx = 8'($random(seed));
         rxb = 8'($random(seed));
         // master on before the peer is armed
         wr(`SPI_CTRL_ADDR, {code[2], 3'b111, 2'b00, code[1:0]});
         @(posedge sys_clk);
         ld <= 1'b1;
         ld_byte <= rxb;
         @(posedge sys_clk);
         ld <= 1'b0;
         wr(`SPI_DATA_ADDR, tx);
         if (code == 3'h3)
            wr(`SPI_DATA_ADDR, ~tx);
         half(h);
         chk(8'(h), half_exp(code));
         for (int k = 0; k < 3000 && irq !== 1'b1; k++)
            @(negedge sys_clk);
         chk({7'h00, irq}, 8'h01);
         rd(`SPI_STAT_ADDR, code == 3'h3 ? 8'hc8 : 8'h88, 8'hff);
         // slow rates only: fast ones outrun the input synchronisers
         rd(`SPI_DATA_ADDR, rxb, code >= 3'h3 ? 8'hff : 8'h00);
         chk(peer_rx, tx);
         rd(`SPI_STAT_ADDR, 8'h08, 8'hff);
      end
      wr(`SPI_MASK_ADDR, 8'h09);
      wr(`SPI_STAT_ADDR, 8'h01);
      repeat (3) @(negedge sys_clk);
      chk({7'h00, irq}, 8'h01);
      wr(`SPI_STAT_ADDR, 8'h00);
      repeat (3) @(negedge sys_clk);
      chk({7'h00, irq}, 8'h00);
      wr(`SPI_MASK_ADDR, 8'h11);
      @(posedge sys_clk);
      ss_n_in <= 1'b0;
      wr(`SPI_CTRL_ADDR, 8'h50);
      repeat (8) @(negedge sys_clk);
      chk({7'h00, irq}, 8'h01);
      rd(`SPI_CTRL_ADDR, 8'h00, 8'hff);
      rd(`SPI_STAT_ADDR, 8'h18, 8'hff);
      wr(`SPI_CTRL_ADDR, 8'h00);
      rd(`SPI_STAT_ADDR, 8'h08, 8'hff);
      @(posedge sys_clk);
      ss_n_in <= 1'b1;
      wr(`SPI_CTRL_ADDR, 8'h78);
      repeat (80) @(negedge sys_clk);
      chk({6'h00, sck_oe, sck_out}, 8'h03);
      wr(`SPI_CTRL_ADDR, 8'h70);
      repeat (80) @(negedge sys_clk);
      chk({6'h00, sck_oe, sck_out}, 8'h02);
      // slave mode: loaded byte, echo, then a byte cut short by select
      sb = 8'($random(seed));
      m1 = 8'($random(seed));
      m2 = 8'($random(seed));
      wr(`SPI_MASK_ADDR, 8'h21);
      wr(`SPI_CTRL_ADDR, 8'h40);
      wr(`SPI_DATA_ADDR, sb);
      ss_n_in <= 1'b0;
      repeat (8) @(posedge sys_clk);
      slv(m1, 8, got);
      chk(got, sb);
      rd(`SPI_STAT_ADDR, 8'h88, 8'hff);
      rd(`SPI_DATA_ADDR, m1, 8'hff);
      slv(m2, 8, got);
      chk(got, m1);
      rd(`SPI_STAT_ADDR, 8'h88, 8'hff);
      rd(`SPI_DATA_ADDR, m2, 8'hff);
      slv(m1, 3, got);
      ss_n_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rd(`SPI_STAT_ADDR, 8'h28, 8'hff);
      chk({7'h00, irq}, 8'h00);
      wr(`SPI_STAT_ADDR, 8'h20);
      rd(`SPI_STAT_ADDR, 8'h28, 8'hff);
      wr(`SPI_CTRL_ADDR, 8'h00);
      rd(`SPI_STAT_ADDR, 8'h08, 8'hff);
      final_report();
   end
endmodule
